/* File: design/odt_pkg.sv */
// constants and types shared by both ends of the odt transition link
package odt_pkg;
    localparam int WL_W   = 4;              // write latency field width
    localparam int CNT_W  = 8;              // window counter width
    localparam int PIPE_D = 16;             // depth of the odt latency pipe

    localparam logic [WL_W-1:0]  WL_RESET  = 4'h5;
    localparam logic             A12_RESET = 1'b0;
    localparam logic [WL_W-1:0]  WL_ONE    = 4'h1;
    localparam logic [WL_W-1:0]  ODTL_OFS  = 4'h2;  // odtlon = wl - 2
    localparam logic [CNT_W-1:0] CNT_ZERO  = 8'h00;
    localparam logic [CNT_W-1:0] CNT_ONE   = 8'h01;

    // asynchronous termination delay, frozen dll
    localparam int CLK_PERIOD_PS  = 100000;
    localparam int TAONPD_MIN_PS  = 2000;
    localparam int TAONPD_MAX_PS  = 8500;
    localparam int AONPD_MIN_RAW  = (TAONPD_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int AONPD_MAX_RAW  = TAONPD_MAX_PS / CLK_PERIOD_PS;
    localparam int AONPD_MIN_CYC  = (AONPD_MIN_RAW < 1) ? 1 : AONPD_MIN_RAW;
    localparam int AONPD_MAX_CYC  = (AONPD_MAX_RAW < 1) ? 1 : AONPD_MAX_RAW;
    localparam int ASYNC_TAP      = AONPD_MIN_CYC - 1;

    // post-edge window lengths in cycles, plain defaults
    localparam logic [CNT_W-1:0] TCPDED_CYC = 8'h01;
    localparam logic [CNT_W-1:0] TRFC_CYC   = 8'h10;
    localparam logic [CNT_W-1:0] TXPDLL_CYC = 8'h0a;

    typedef enum logic [1:0] {
        ST_IDLE     = 2'b00,
        ST_ENTRY_LB = 2'b01,
        ST_PDOWN    = 2'b10,
        ST_EXIT_LB  = 2'b11
    } host_state_e;

    // larger of two counts
    function automatic logic [CNT_W-1:0] cntMax(input logic [CNT_W-1:0] a, input logic [CNT_W-1:0] b);
        cntMax = (a > b) ? a : b;
    endfunction : cntMax
endpackage : odt_pkg

/* File: design/odt_link_if.sv */
// link between the memory controller and the termination logic
`timescale 1ns/100ps
`default_nettype none
interface odt_link_if
    import odt_pkg::*;
(
    input wire logic clk,
    input wire logic rstn
);
    logic            cke;       // clock enable
    logic            odt;       // termination request pin
    logic            refresh;   // refresh command strobe
    logic            mrsLoad;   // mode register load strobe
    logic            mrsA12;    // dll kept on in power-down when high
    logic [WL_W-1:0] mrsWl;     // write latency

    modport host (
        input  clk, rstn,
        output cke, odt, refresh, mrsLoad, mrsA12, mrsWl
    );
    modport device (
        input  clk, rstn,
        input  cke, odt, refresh, mrsLoad, mrsA12, mrsWl
    );
endinterface : odt_link_if
`default_nettype wire

/* File: design/odt_window_counter.sv */
// down counter that marks a transition window, extended by reloads
`timescale 1ns/100ps
`default_nettype none
module odt_window_counter
    import odt_pkg::*;
#(
    parameter int CW = CNT_W
) (
    input  wire logic          clk,
    input  wire logic          rstn,
    input  wire logic          load,
    input  wire logic [CW-1:0] loadValue,
    output logic               busy,
    output logic [CW-1:0]      count
);
    logic [CW-1:0] count_q;
    logic [CW-1:0] count_d;
    logic [CW-1:0] dec;

    // a reload never shortens a running window, so overlaps merge
    always_comb begin
        dec     = (count_q != '0) ? count_q - CW'(1) : '0;
        count_d = (load && (loadValue > dec)) ? loadValue : dec;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            count_q <= '0;
        end else begin
            count_q <= count_d;
        end
    end

    assign busy  = (count_q != '0);
    assign count = count_q;
endmodule : odt_window_counter
`default_nettype wire

/* File: design/odt_host_end.sv */
// controller end: drives cke, odt and commands and tracks windows
`timescale 1ns/100ps
`default_nettype none
module odt_host_end
    import odt_pkg::*;
#(
    parameter logic [CNT_W-1:0] TCPDED = TCPDED_CYC,
    parameter logic [CNT_W-1:0] TRFC   = TRFC_CYC,
    parameter logic [CNT_W-1:0] TXPDLL = TXPDLL_CYC
) (
    odt_link_if.host        link,
    input  wire logic       pdReq,
    input  wire logic       refreshReq,
    input  wire logic       odtReq,
    input  wire logic       mrsReq,
    input  wire logic       mrsA12In,
    input  wire logic [WL_W-1:0] mrsWlIn,
    output logic            windowActive,
    output logic            poweredDown
);
    host_state_e      state_q,   state_d;
    logic [WL_W-1:0]  lbCnt_q,   lbCnt_d;
    logic [CNT_W-1:0] rfcCnt_q,  rfcCnt_d;
    logic             cke_q,     cke_d;
    logic             odt_q,     odt_d;
    logic             ref_q,     ref_d;
    logic             mrs_q,     mrs_d;
    logic             a12_q,     a12_d;
    logic [WL_W-1:0]  wl_q,      wl_d;
    logic             winLoad;
    logic [CNT_W-1:0] winValue;
    logic             winBusy;

    // power-down sequencing, commands only from idle
    always_comb begin
        state_d  = state_q;
        lbCnt_d  = lbCnt_q;
        cke_d    = cke_q;
        odt_d    = odtReq;
        ref_d    = 1'b0;
        mrs_d    = 1'b0;
        a12_d    = a12_q;
        wl_d     = wl_q;
        winLoad  = 1'b0;
        winValue = CNT_ZERO;
        rfcCnt_d = (rfcCnt_q != CNT_ZERO) ? rfcCnt_q - CNT_ONE : CNT_ZERO;
        case (state_q)
            ST_IDLE: begin
                if (mrsReq) begin
                    mrs_d = 1'b1;
                    a12_d = mrsA12In;
                    wl_d  = mrsWlIn;
                end else if (refreshReq) begin
                    ref_d    = 1'b1;
                    rfcCnt_d = TRFC;
                end else if (pdReq) begin
                    state_d = ST_ENTRY_LB;
                    lbCnt_d = wl_q - WL_ONE;
                end
            end
            ST_ENTRY_LB: begin
                lbCnt_d = lbCnt_q - WL_ONE;
                if (lbCnt_q <= WL_ONE) begin
                    state_d  = ST_PDOWN;
                    cke_d    = 1'b0;
                    winLoad  = 1'b1;
                    winValue = cntMax(TCPDED, rfcCnt_d);
                end
            end
            ST_PDOWN: begin
                if (!pdReq) begin
                    state_d = ST_EXIT_LB;
                    lbCnt_d = wl_q - WL_ONE;
                end
            end
            ST_EXIT_LB: begin
                lbCnt_d = lbCnt_q - WL_ONE;
                if (lbCnt_q <= WL_ONE) begin
                    state_d  = ST_IDLE;
                    cke_d    = 1'b1;
                    winLoad  = 1'b1;
                    winValue = TXPDLL;
                end
            end
            default: begin
                state_d = ST_IDLE;
                cke_d   = 1'b1;
            end
        endcase
    end

    always_ff @(posedge link.clk or negedge link.rstn) begin
        if (!link.rstn) begin
            state_q  <= ST_IDLE;
            lbCnt_q  <= '0;
            rfcCnt_q <= CNT_ZERO;
            cke_q    <= 1'b1;
            odt_q    <= 1'b0;
            ref_q    <= 1'b0;
            mrs_q    <= 1'b0;
            a12_q    <= A12_RESET;
            wl_q     <= WL_RESET;
        end else begin
            state_q  <= state_d;
            lbCnt_q  <= lbCnt_d;
            rfcCnt_q <= rfcCnt_d;
            cke_q    <= cke_d;
            odt_q    <= odt_d;
            ref_q    <= ref_d;
            mrs_q    <= mrs_d;
            a12_q    <= a12_d;
            wl_q     <= wl_d;
        end
    end

    // post-edge part of each window
    odt_window_counter #(.CW(CNT_W)) postWindow (
        .clk       (link.clk),
        .rstn      (link.rstn),
        .load      (winLoad),
        .loadValue (winValue),
        .busy      (winBusy),
        .count     ()
    );

    // look-back states plus post-edge count, only with frozen dll
    assign windowActive = !a12_q && (state_q == ST_ENTRY_LB || state_q == ST_EXIT_LB || winBusy);
    assign poweredDown  = !cke_q;

    assign link.cke     = cke_q;
    assign link.odt     = odt_q;
    assign link.refresh = ref_q;
    assign link.mrsLoad = mrs_q;
    assign link.mrsA12  = a12_q;
    assign link.mrsWl   = wl_q;
endmodule : odt_host_end
`default_nettype wire

/* File: design/odt_device_end.sv */
// device end: chooses synchronous or asynchronous termination response
`timescale 1ns/100ps
`default_nettype none
module odt_device_end
    import odt_pkg::*;
#(
    parameter logic [CNT_W-1:0] TCPDED = TCPDED_CYC,
    parameter logic [CNT_W-1:0] TRFC   = TRFC_CYC,
    parameter logic [CNT_W-1:0] TXPDLL = TXPDLL_CYC
) (
    odt_link_if.device      link,
    output logic            rttOn,
    output logic            odtUncertain,
    output logic            asyncMode,
    output logic            powerDown
);
    // mode register copy
    logic             a12_q,    a12_d;
    logic [WL_W-1:0]  wl_q,     wl_d;

    // registered pins and refresh tracking
    logic             ckeReg_q, ckeReg_d;
    logic [CNT_W-1:0] rfcCnt_q, rfcCnt_d;

    // odt latency pipe and termination output
    logic [PIPE_D-1:0] pipe_q,  pipe_d;
    logic              rtt_q,   rtt_d;
    logic              async_q, async_d;

    // edge detection and window loading
    logic             ckeFall;
    logic             ckeRise;
    logic             winLoad;
    logic [CNT_W-1:0] winValue;
    logic [CNT_W-1:0] lookBack;
    logic             winBusy;
    logic [WL_W-1:0]  syncTap;
    logic             syncBit;
    logic             asyncBit;
    logic             asyncSel;

    // mode register capture
    always_comb begin
        a12_d = a12_q;
        wl_d  = wl_q;
        if (link.mrsLoad) begin
            a12_d = link.mrsA12;
            wl_d  = link.mrsWl;
        end
    end

    always_ff @(posedge link.clk or negedge link.rstn) begin
        if (!link.rstn) begin
            a12_q <= A12_RESET;
            wl_q  <= WL_RESET;
        end else begin
            a12_q <= a12_d;
            wl_q  <= wl_d;
        end
    end

    // cke is registered each edge; refresh holds trfc remaining
    always_comb begin
        ckeReg_d = link.cke;
        if (link.refresh) begin
            rfcCnt_d = TRFC;
        end else if (rfcCnt_q != CNT_ZERO) begin
            rfcCnt_d = rfcCnt_q - CNT_ONE;
        end else begin
            rfcCnt_d = CNT_ZERO;
        end
    end

    always_ff @(posedge link.clk or negedge link.rstn) begin
        if (!link.rstn) begin
            ckeReg_q <= 1'b1;
            rfcCnt_q <= CNT_ZERO;
        end else begin
            ckeReg_q <= ckeReg_d;
            rfcCnt_q <= rfcCnt_d;
        end
    end

    // first cycle that cke is seen low or high
    assign ckeFall = ckeReg_q && !link.cke;
    assign ckeRise = !ckeReg_q && link.cke;

    // look-back length taken from the programmed write latency
    assign lookBack = CNT_W'(wl_q) - CNT_ONE;

    // window load: entry is the later of cpded and trfc, exit is txpdll
    always_comb begin
        winLoad  = 1'b0;
        winValue = CNT_ZERO;
        if (!a12_q) begin
            if (ckeFall) begin
                winLoad  = 1'b1;
                winValue = lookBack + cntMax(TCPDED, rfcCnt_q);
            end else if (ckeRise) begin
                winLoad  = 1'b1;
                winValue = lookBack + TXPDLL;
            end
        end
    end

    // span counter, reloads merge overlapping windows
    odt_window_counter #(.CW(CNT_W)) spanCounter (
        .clk       (link.clk),
        .rstn      (link.rstn),
        .load      (winLoad),
        .loadValue (winValue),
        .busy      (winBusy),
        .count     ()
    );

    // odt pin shifted one stage per cycle; stage 0 is odt sampled
    always_comb begin
        pipe_d = {pipe_q[PIPE_D-2:0], link.odt};
    end

    // tap one stage short of odtlon: the output flop adds the last cycle; tiny latencies clamp
    assign syncTap  = (wl_q > ODTL_OFS) ? wl_q - ODTL_OFS - WL_ONE : '0;
    assign syncBit  = pipe_q[syncTap];
    assign asyncBit = pipe_q[ASYNC_TAP];

    // async while powered down with frozen dll and until the exit window ends
    assign asyncSel = !a12_q && (!link.cke || winBusy || winLoad);

    // termination follows the chosen path, registered for a clean output
    always_comb begin
        async_d = asyncSel;
        rtt_d   = asyncSel ? asyncBit : syncBit;
    end

    always_ff @(posedge link.clk or negedge link.rstn) begin
        if (!link.rstn) begin
            pipe_q  <= '0;
            rtt_q   <= 1'b0;
            async_q <= 1'b0;
        end else begin
            pipe_q  <= pipe_d;
            rtt_q   <= rtt_d;
            async_q <= async_d;
        end
    end

    // status outputs
    assign rttOn        = rtt_q;
    assign asyncMode    = async_q;
    assign odtUncertain = winBusy;
    assign powerDown    = !ckeReg_q;
endmodule : odt_device_end
`default_nettype wire

/* File: sim/odt_link_properties.sv */
// concurrent checks on the odt link and the device outputs
`timescale 1ns/100ps
`default_nettype none
module odt_link_properties
    import odt_pkg::*;
#(
    parameter logic [CNT_W-1:0] TCPDED = TCPDED_CYC
) (
    input wire logic            clk,
    input wire logic            rstn,
    input wire logic            cke,
    input wire logic            odt,
    input wire logic            refresh,
    input wire logic            mrsLoad,
    input wire logic            mrsA12,
    input wire logic [WL_W-1:0] mrsWl,
    input wire logic            rttOn,
    input wire logic            odtUncertain,
    input wire logic            asyncMode,
    input wire logic            powerDown
);
    logic       odt_q, odt_d;
    logic [7:0] age_q, age_d, calm_q, calm_d, unc_q, unc_d;
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    // age of odt level, cycles without async mode, length of uncertain run
    always_comb begin
        odt_d = odt;
        age_d = (odt != odt_q) ? 8'h00 : age_q + {7'h0, age_q != 8'hff};
        calm_d = asyncMode ? 8'h00 : calm_q + {7'h0, calm_q != 8'hff};
        unc_d = odtUncertain ? unc_q + 8'h01 : 8'h00;
    end
    // helper registers
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            odt_q <= 1'b0;
            age_q <= 8'h00;
            calm_q <= 8'h00;
            unc_q <= 8'h00;
        end else begin
            odt_q <= odt_d;
            age_q <= age_d;
            calm_q <= calm_d;
            unc_q <= unc_d;
        end
    end
    a_pd_follows_cke: assert property (powerDown == !$past(cke))
        else $error("power-down flag off cke");
    a_entry_async: assert property ($fell(cke) && !mrsA12 |-> ##[1:2] asyncMode)
        else $error("no async mode at entry");
    a_entry_uncertain: assert property ($fell(cke) && !mrsA12 |-> ##[1:2] odtUncertain)
        else $error("no uncertain flag at entry");
    a_a12_sync: assert property ($fell(cke) && mrsA12 |=> !asyncMode [*4])
        else $error("async mode with dll kept on");
    a_exit_hold: assert property ($rose(cke) && !mrsA12 |-> asyncMode [*8])
        else $error("exit window cut short");
    a_async_on: assert property ($rose(odt) ##0 asyncMode [*3] |-> ##[0:1] rttOn)
        else $error("async turn-on late");
    a_async_off: assert property ($fell(odt) ##0 asyncMode [*3] |-> ##[0:1] !rttOn)
        else $error("async turn-off late");
    a_sync_latency: assert property ($rose(rttOn) && calm_q > 8'h10 |->
        age_q + 8'h02 >= {4'h0, mrsWl} && age_q <= {4'h0, mrsWl})
        else $error("sync turn-on off latency");
    a_uncertain_span: assert property ($fell(odtUncertain) |->
        unc_q + 8'h01 >= {4'h0, mrsWl} + TCPDED)
        else $error("uncertain span too short");
    c_entry: cover property ($fell(cke) && !mrsA12);
    c_refresh_entry: cover property (refresh ##[1:8] $fell(cke));
    c_frozen_off: cover property (mrsLoad ##[1:40] ($fell(cke) && mrsA12));
endmodule : odt_link_properties
`default_nettype wire

/* File: sim/tb.sv */
// self-checking bench: host and device ends facing each other
`timescale 1ns/100ps
`default_nettype none
module tb;
    import odt_pkg::*;
    logic            clk = 1'b0;
    logic            rstn = 1'b0;
    logic            pdReq = 1'b0;
    logic            refreshReq = 1'b0;
    logic            odtReq = 1'b0;
    logic            mrsReq = 1'b0;
    logic            mrsA12In = 1'b0;
    logic [WL_W-1:0] mrsWlIn = 4'h5;
    logic            windowActive, poweredDown, rttOn, odtUncertain, asyncMode, powerDown;
    logic [15:0]     wl = 16'h5;
    logic [15:0]     c;
    int              error_cnt = 0;
    int              n_checks = 0;
    // 100 ns clock
    always #50 clk = ~clk;
    odt_link_if lnk (.clk, .rstn);
    odt_host_end i_odt_host_end (.link(lnk), .pdReq, .refreshReq, .odtReq, .mrsReq, .mrsA12In,
        .mrsWlIn, .windowActive, .poweredDown);
    odt_device_end i_odt_device_end (.link(lnk), .rttOn, .odtUncertain, .asyncMode, .powerDown);
    odt_link_properties #(.TCPDED(TCPDED_CYC)) chk_props (.clk, .rstn, .cke(lnk.cke),
        .odt(lnk.odt), .refresh(lnk.refresh), .mrsLoad(lnk.mrsLoad), .mrsA12(lnk.mrsA12),
        .mrsWl(lnk.mrsWl), .rttOn, .odtUncertain, .asyncMode, .powerDown);
    // compare and count
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %0d seen %0d", nm, e, g);
        end
    endtask : chk
    task automatic cyc(input int k);
        repeat (k) @(negedge clk);
    endtask : cyc
    // falling edges until s shows v, bounded
    task automatic lat(ref logic s, input logic v);
        c = 16'h0;
        while (s !== v && c < 16'd80) begin
            @(negedge clk);
            c++;
        end
    endtask : lat
    // raise then drop odt, timing both termination changes
    task automatic odtLat(input logic [15:0] e);
        odtReq = 1'b1;
        lat(rttOn, 1'b1);
        chk("rtt on delay", e, c);
        cyc(6);
        odtReq = 1'b0;
        lat(rttOn, 1'b0);
        chk("rtt off delay", e, c);
        cyc(6);
    endtask : odtLat
    task automatic mrs(input logic a, input logic [WL_W-1:0] w);
        mrsA12In = a;
        mrsWlIn = w;
        mrsReq = 1'b1;
        cyc(1);
        mrsReq = 1'b0;
        cyc(3);
    endtask : mrs
    task automatic pd(input logic v);
        pdReq = v;
        lat(poweredDown, v);
    endtask : pd
    task automatic print_verdict();
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : print_verdict
    // watchdog: the sequence needs well under 1000 cycles
    initial begin
        #(4000 * 100);
        error_cnt++;
        print_verdict();
    end
    // main sequence
    initial begin
        cyc(5);
        rstn = 1'b1;
        chk("outs at reset", 16'h0, {10'h0, windowActive, poweredDown, rttOn, odtUncertain, asyncMode, powerDown});
        chk("link at reset", 16'h105, {7'h0, lnk.cke, lnk.odt, lnk.refresh, lnk.mrsLoad, lnk.mrsA12, lnk.mrsWl});
        odtLat(wl);
        mrs(1'b0, 4'h7);
        wl = 16'h7;
        odtLat(wl);
        mrs(1'b0, 4'h5);
        wl = 16'h5;
        // entry without refresh, then async response in power-down
        pdReq = 1'b1;
        lat(windowActive, 1'b1);
        chk("window opens", 16'h1, c);
        lat(poweredDown, 1'b1);
        chk("look-back", wl - 16'h1, c);
        lat(odtUncertain, 1'b1);
        lat(odtUncertain, 1'b0);
        chk("entry window", wl - 16'h1 + TCPDED_CYC, c);
        odtLat(16'h3);
        mrs(1'b1, 4'h9);
        chk("mode load refused", 16'h5, {11'h0, lnk.mrsA12, lnk.mrsWl});
        pdReq = 1'b0;
        lat(poweredDown, 1'b0);
        chk("exit look-back", wl, c);
        lat(powerDown, 1'b0);
        lat(odtUncertain, 1'b0);
        chk("exit window", wl - 16'h1 + TXPDLL_CYC, c);
        // the mode flag is registered, so it drops one cycle after the span ends
        lat(asyncMode, 1'b0);
        chk("async mode trails", 16'h1, c);
        odtLat(wl);
        // refresh just before entry stretches the window
        refreshReq = 1'b1;
        cyc(1);
        refreshReq = 1'b0;
        pdReq = 1'b1;
        lat(odtUncertain, 1'b1);
        lat(odtUncertain, 1'b0);
        chk("refresh stretch", 16'h1, 16'(c > wl - 16'h1 + TCPDED_CYC && c <= wl - 16'h1 + TRFC_CYC));
        pdReq = 1'b0;
        cyc(30);
        // short power-down: entry and exit windows merge
        pd(1'b1);
        pd(1'b0);
        odtLat(16'h3);
        cyc(30);
        // short idle: exit window runs into the next entry
        pd(1'b1);
        cyc(8);
        pd(1'b0);
        pd(1'b1);
        chk("idle merge", 16'h1, {15'h0, asyncMode});
        pd(1'b0);
        cyc(30);
        // dll kept on: no windows, synchronous in power-down
        mrs(1'b1, 4'h5);
        pd(1'b1);
        cyc(3);
        chk("no async mode", 16'h0, {15'h0, asyncMode});
        chk("no host window", 16'h0, {15'h0, windowActive});
        odtLat(wl);
        pd(1'b0);
        cyc(10);
        print_verdict();
    end
endmodule : tb
`default_nettype wire
